// ==== hdl/start_seq_defs.svh ====
/*
  timing counts and field codes for the start sequencer.
  assumes inclusion by bare name from the design file.
*/
`ifndef START_SEQ_DEFS_SVH
`define START_SEQ_DEFS_SVH

// base tick for stationary timeout, in microseconds
`define STAT_TICK_US 32'd1000
`define CLK_MHZ 32'd25
`define STAT_TICK_CYC (`STAT_TICK_US * `CLK_MHZ)
// brake base time, milliseconds
`define BRAKE_TICK_MS 32'd10
`define BRAKE_TICK_CYC (`BRAKE_TICK_MS * 32'd1000 * `CLK_MHZ)
// align base time, milliseconds
`define ALIGN_TICK_MS 32'd40
`define ALIGN_TICK_CYC (`ALIGN_TICK_MS * 32'd1000 * `CLK_MHZ)
// probe pulse spacing base, microseconds
`define PROBE_GAP_US 32'd100
`define PROBE_GAP_CYC (`PROBE_GAP_US * `CLK_MHZ)
// number of probe pairs
`define PROBE_PAIRS 3'd6
// advance step per code, in degrees (code*30 deg)
`define ADV_STEP_DEG 8'd30
`define BRAKE_OFF 3'h0
`define PROBE_OFF 4'h0
`define RATE_W 16
`define TIME_W 24

`endif

// ==== hdl/start_seq_pkg.sv ====
/*
  types shared by the start sequencer.
  assumes the defs header is on the include path.
*/
package start_seq_pkg;
  typedef enum logic [3:0] {
    ST_POWER_ON = 4'h0,
    ST_SPEED_PROBE = 4'h1,
    ST_SPEED_JUDGE = 4'h2,
    ST_REV_JUDGE = 4'h3,
    ST_REV_DRIVE = 4'h4,
    ST_BRAKE_JUDGE = 4'h5,
    ST_BRAKE = 4'h6,
    ST_PROBE_JUDGE = 4'h7,
    ST_ALIGN = 4'h8,
    ST_POS_PROBE = 4'h9,
    ST_ACCEL = 4'hA,
    ST_RUN = 4'hB
  } seq_state_e;

  // per-phase drive: high side on, low side on
  typedef struct packed {
    logic [2:0] hi_on;
    logic [2:0] lo_on;
  } phase_drive_s;

  typedef struct packed {
    logic speed_probe_enable;
    logic [1:0] stationary_timeout_sel;
    logic [1:0] reverse_speed_limit;
    logic reverse_drive_enable;
    logic [2:0] brake_duration_sel;
    logic [3:0] position_probe_current_limit;
    logic [2:0] align_duration_sel;
    logic [1:0] open_loop_current_sel;
    logic [2:0] accel_first_order;
    logic [2:0] accel_second_order;
    logic [4:0] handoff_speed_threshold;
    logic probe_release_mode;
    logic [1:0] probe_pulse_rate;
    logic [1:0] probe_advance_angle;
  } seq_cfg_s;
endpackage

// ==== hdl/start_sequencer.sv ====
/*
  start sequencer: takes a motor from any initial condition to feedback running.
  assumes synchronous comparator, current-limit and direction inputs; power stage outside.
*/
`timescale 1ns/1ns
`include "start_seq_defs.svh"

module start_sequencer #(
  parameter int RATE_W = `RATE_W,
  parameter int TIME_W = `TIME_W,
  parameter int STAT_TICK = `STAT_TICK_CYC,
  parameter int BRAKE_TICK = `BRAKE_TICK_CYC,
  parameter int ALIGN_TICK = `ALIGN_TICK_CYC,
  parameter int PROBE_GAP = `PROBE_GAP_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  // power mode and pins
  input wire logic wake_restart,
  input wire logic dir_pin,
  input wire start_seq_pkg::seq_cfg_s cfg,
  // sensing
  input wire logic cmp_uv,
  input wire logic cmp_uw,
  input wire logic current_at_limit,
  // outputs
  output start_seq_pkg::phase_drive_s drive,
  output start_seq_pkg::seq_state_e state,
  output logic [RATE_W-1:0] drive_rate,
  output logic [7:0] drive_angle,
  output logic [1:0] current_sel
);
  import start_seq_pkg::*;

  initial begin
    if (RATE_W < 8 || TIME_W < 16 || STAT_TICK < 1 || BRAKE_TICK < 1 || ALIGN_TICK < 1 || PROBE_GAP < 1) begin
      $error("start_sequencer: bad parameters");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [TIME_W-1:0] scale(input logic [2:0] sel, input int tick);
    scale = TIME_W'(tick) << sel;
  endfunction

  // pair index to drive pattern: VW WV UV VU WU UW (phase bit 0=U,1=V,2=W)
  function automatic phase_drive_s pair_drive(input logic [2:0] idx);
    phase_drive_s d;
    d = '0;
    case (idx)
      3'h0: begin d.hi_on = 3'b010; d.lo_on = 3'b100; end
      3'h1: begin d.hi_on = 3'b100; d.lo_on = 3'b010; end
      3'h2: begin d.hi_on = 3'b001; d.lo_on = 3'b010; end
      3'h3: begin d.hi_on = 3'b010; d.lo_on = 3'b001; end
      3'h4: begin d.hi_on = 3'b100; d.lo_on = 3'b001; end
      3'h5: begin d.hi_on = 3'b001; d.lo_on = 3'b100; end
      default: d = '0;
    endcase
    pair_drive = d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  seq_state_e state_ff, nxt_state;
  phase_drive_s drive_ff, nxt_drive;
  logic [TIME_W-1:0] tmr_ff, nxt_tmr;
  logic [TIME_W-1:0] period_ff, nxt_period;
  logic [TIME_W-1:0] best_ff, nxt_best;
  logic [2:0] best_idx_ff, nxt_best_idx;
  logic [2:0] pair_ff, nxt_pair;
  logic pulse_on_ff, nxt_pulse_on;
  logic edge_seen_ff, nxt_edge_seen;
  logic fwd_ff, nxt_fwd;
  logic [RATE_W-1:0] rate_ff, nxt_rate;
  logic [RATE_W-1:0] accel_ff, nxt_accel;
  logic [7:0] angle_ff, nxt_angle;
  logic [1:0] current_sel_ff, nxt_current_sel;
  logic dir_q_ff, uv_q_ff, uw_q_ff;
  logic uv_rise, uw_rise, dir_change;
  logic [RATE_W-1:0] meas_rate;

  assign uv_rise = cmp_uv & ~uv_q_ff;
  assign uw_rise = cmp_uw & ~uw_q_ff;
  assign dir_change = dir_pin ^ dir_q_ff;
  assign meas_rate = (period_ff == '0) ? '1 : RATE_W'((TIME_W)'(32'hFFFFFF) / period_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_drive = '0;
    nxt_tmr = tmr_ff + 1'b1;
    nxt_period = period_ff;
    nxt_best = best_ff;
    nxt_best_idx = best_idx_ff;
    nxt_pair = pair_ff;
    nxt_pulse_on = pulse_on_ff;
    nxt_edge_seen = edge_seen_ff;
    nxt_fwd = fwd_ff;
    nxt_rate = rate_ff;
    nxt_accel = accel_ff;
    nxt_angle = angle_ff;
    nxt_current_sel = cfg.open_loop_current_sel;
    case (state_ff)
      ST_POWER_ON: begin
        nxt_tmr = '0;
        nxt_edge_seen = 1'b0;
        nxt_rate = '0;
        nxt_accel = '0;
        nxt_state = cfg.speed_probe_enable ? ST_SPEED_PROBE : ST_BRAKE_JUDGE;
      end
      ST_SPEED_PROBE: begin
        nxt_drive = '0;
        if (uv_rise || uw_rise) begin
          // direction from order
          // forward: uv already high when uw rises, uw still low when uv rises
          if (uw_rise) nxt_fwd = cmp_uv;
          else nxt_fwd = ~cmp_uw;
          if (edge_seen_ff) begin
            nxt_period = tmr_ff;
            nxt_state = ST_SPEED_JUDGE;
          end
          nxt_edge_seen = 1'b1;
          nxt_tmr = '0;
          nxt_angle = cmp_uw ? 8'd0 : 8'd180;
        end else if (tmr_ff >= scale({1'b0, cfg.stationary_timeout_sel}, STAT_TICK)) begin
          nxt_period = '0;
          nxt_state = ST_SPEED_JUDGE;
        end
      end
      ST_SPEED_JUDGE: begin
        nxt_tmr = '0;
        nxt_edge_seen = 1'b0;
        if (period_ff == '0 || period_ff > scale({1'b0, cfg.stationary_timeout_sel}, STAT_TICK)) begin
          nxt_state = ST_BRAKE_JUDGE;
        end else if (fwd_ff) begin
          nxt_rate = meas_rate;
          nxt_state = ST_RUN;
        end else begin
          nxt_state = ST_REV_JUDGE;
        end
      end
      ST_REV_JUDGE: begin
        nxt_tmr = '0;
        if (meas_rate > (RATE_W'(1) << ({1'b0, cfg.reverse_speed_limit} + 3'd2))) begin
          nxt_state = ST_SPEED_PROBE;
        end else begin
          nxt_rate = meas_rate;
          nxt_state = cfg.reverse_drive_enable ? ST_REV_DRIVE : ST_BRAKE_JUDGE;
        end
      end
      ST_REV_DRIVE: begin
        nxt_drive = pair_drive(3'h0);
        if (rate_ff > RATE_W'(cfg.accel_first_order) + 1'b1) begin
          nxt_rate = rate_ff - RATE_W'(cfg.accel_first_order) - 1'b1;
        end else begin
          nxt_rate = '0;
          nxt_state = ST_ACCEL;
        end
      end
      ST_BRAKE_JUDGE: begin
        nxt_tmr = '0;
        nxt_state = (cfg.brake_duration_sel != `BRAKE_OFF) ? ST_BRAKE : ST_PROBE_JUDGE;
      end
      ST_BRAKE: begin
        nxt_drive.lo_on = 3'b111;
        if (tmr_ff >= scale(cfg.brake_duration_sel, BRAKE_TICK)) begin
          nxt_tmr = '0;
          nxt_drive = '0;
          nxt_state = ST_PROBE_JUDGE;
        end
      end
      ST_PROBE_JUDGE: begin
        nxt_tmr = '0;
        nxt_pair = '0;
        nxt_pulse_on = 1'b1;
        nxt_best = '1;
        nxt_state = (cfg.position_probe_current_limit != `PROBE_OFF) ? ST_POS_PROBE : ST_ALIGN;
      end
      ST_ALIGN: begin
        nxt_drive = pair_drive(3'h0);
        nxt_angle = 8'd0;
        if (tmr_ff >= scale(cfg.align_duration_sel, ALIGN_TICK)) begin
          nxt_tmr = '0;
          nxt_state = ST_ACCEL;
        end
      end
      ST_POS_PROBE: begin
        if (pulse_on_ff) begin
          nxt_drive = pair_drive(pair_ff);
          if (current_at_limit) begin
            if (tmr_ff < best_ff) begin
              nxt_best = tmr_ff;
              nxt_best_idx = pair_ff;
            end
            nxt_drive = '0;
            if (!cfg.probe_release_mode) nxt_drive.lo_on = pair_drive(pair_ff).lo_on;
            nxt_pulse_on = 1'b0;
            nxt_tmr = '0;
          end
        end else begin
          if (!cfg.probe_release_mode) nxt_drive.lo_on = pair_drive(pair_ff).lo_on;
          if (tmr_ff >= scale({1'b0, cfg.probe_pulse_rate}, PROBE_GAP)) begin
            nxt_tmr = '0;
            nxt_drive = '0;
            if (pair_ff == `PROBE_PAIRS - 3'd1) begin
              nxt_angle = 8'(best_idx_ff * 8'd60 + cfg.probe_advance_angle * `ADV_STEP_DEG);
              nxt_state = ST_ACCEL;
            end else begin
              nxt_pair = pair_ff + 3'd1;
              nxt_pulse_on = 1'b1;
            end
          end
        end
      end
      ST_ACCEL: begin
        nxt_drive = pair_drive(pair_ff);
        nxt_accel = accel_ff + RATE_W'(cfg.accel_second_order);
        nxt_rate = rate_ff + RATE_W'(cfg.accel_first_order) + accel_ff;
        nxt_angle = angle_ff + 8'(rate_ff[RATE_W-1 -: 4]);
        if (rate_ff > (RATE_W'(cfg.handoff_speed_threshold) << 3)) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_drive = pair_drive(pair_ff);
        nxt_tmr = '0;
      end
      default: nxt_state = ST_POWER_ON;
    endcase
    if (dir_change) begin
      nxt_drive = '0;
      nxt_state = ST_POWER_ON;
    end
    if (wake_restart) begin
      nxt_drive = '0;
      nxt_state = ST_POWER_ON;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_POWER_ON;
      drive_ff <= '0;
      tmr_ff <= '0;
      period_ff <= '0;
      best_ff <= '1;
      best_idx_ff <= '0;
      pair_ff <= '0;
      pulse_on_ff <= 1'b0;
      edge_seen_ff <= 1'b0;
      fwd_ff <= 1'b0;
      rate_ff <= '0;
      accel_ff <= '0;
      angle_ff <= '0;
      current_sel_ff <= 2'h0;
      dir_q_ff <= 1'b0;
      uv_q_ff <= 1'b0;
      uw_q_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      drive_ff <= nxt_drive;
      tmr_ff <= nxt_tmr;
      period_ff <= nxt_period;
      best_ff <= nxt_best;
      best_idx_ff <= nxt_best_idx;
      pair_ff <= nxt_pair;
      pulse_on_ff <= nxt_pulse_on;
      edge_seen_ff <= nxt_edge_seen;
      fwd_ff <= nxt_fwd;
      rate_ff <= nxt_rate;
      accel_ff <= nxt_accel;
      angle_ff <= nxt_angle;
      current_sel_ff <= nxt_current_sel;
      dir_q_ff <= dir_pin;
      uv_q_ff <= cmp_uv;
      uw_q_ff <= cmp_uw;
    end
  end

  assign drive = drive_ff;
  assign state = state_ff;
  assign drive_rate = rate_ff;
  assign drive_angle = angle_ff;
  assign current_sel = current_sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_wake_power_on: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && wake_restart |=> state_ff == ST_POWER_ON) else $error("wake did not restart");
  a_probe_branch: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && state_ff == ST_POWER_ON && !wake_restart && !dir_change |=>
    state_ff == (cfg.speed_probe_enable ? ST_SPEED_PROBE : ST_BRAKE_JUDGE)) else $error("bad power-on branch");
  a_brake_skip: assert property (@(posedge mclk) disable iff (!nrst)
    state_ff == ST_BRAKE && $past(state_ff) != ST_BRAKE |-> $past(cfg.brake_duration_sel) != `BRAKE_OFF)
    else $error("brake with zero duration");
  a_brake_lows: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && state_ff == ST_BRAKE && nxt_state == ST_BRAKE |=> drive_ff.lo_on == 3'b111 && drive_ff.hi_on == 3'b000)
    else $error("brake drive wrong");
  a_probe_float: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && state_ff == ST_SPEED_PROBE |=> drive_ff == '0) else $error("phases driven during speed probe");
  a_dir_restart: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && dir_change |=> state_ff == ST_POWER_ON && drive_ff == '0) else $error("dir change ignored");
  a_probe_select: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && state_ff == ST_PROBE_JUDGE && !dir_change && !wake_restart |=>
    state_ff == ($past(cfg.position_probe_current_limit) != `PROBE_OFF ? ST_POS_PROBE : ST_ALIGN))
    else $error("probe selection wrong");
  a_align_pattern: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && state_ff == ST_ALIGN && nxt_state == ST_ALIGN |=> drive_ff.hi_on == 3'b010 && drive_ff.lo_on == 3'b100)
    else $error("align pattern wrong");
  a_release_hiz: assert property (@(posedge mclk) disable iff (!nrst)
    clk_en && state_ff == ST_POS_PROBE && pulse_on_ff && current_at_limit && cfg.probe_release_mode
    && !dir_change && !wake_restart |=> drive_ff == '0) else $error("hi-z release drives");

  c_resync: cover property (@(posedge mclk) state_ff == ST_SPEED_JUDGE ##1 state_ff == ST_RUN);
  c_brake: cover property (@(posedge mclk) state_ff == ST_BRAKE ##1 state_ff == ST_PROBE_JUDGE);
  c_probe_done: cover property (@(posedge mclk) state_ff == ST_POS_PROBE ##1 state_ff == ST_ACCEL);
  c_handoff: cover property (@(posedge mclk) state_ff == ST_ACCEL ##1 state_ff == ST_RUN);
endmodule // start_sequencer

// ==== tb/motor_model.sv ====
/*
  motor model: comparator levels of a coasting motor and winding current rise under probe pulses.
  assumes drive from the start sequencer and a free running clock.
*/
`timescale 1ns/1ns
module motor_model (
  // clock
  input wire logic mclk,
  // scenario control
  input wire logic [1:0] spin,
  input wire logic [5:0] best_pat,
  // sequencer side
  input wire start_seq_pkg::phase_drive_s drive,
  output logic cmp_uv,
  output logic cmp_uw,
  output logic current_at_limit
);
  import start_seq_pkg::*;
  localparam int PER = 12;
  int ph = 0;
  int rise = 0;
  ////////////////////////////////////////////////////////////////
  // electrical phase and current rise time
  always @(posedge mclk) begin
    ph <= (ph + 1) % PER;
    if (drive.hi_on != 3'h0) rise <= rise + 1;
    else rise <= 0;
  end
  // spin 1 forward (uw lags uv by 60 deg), 2 reverse, 0 still
  always_comb begin
    cmp_uv = (spin != 2'h0) && (ph < PER / 2);
    cmp_uw = 1'b0;
    if (spin == 2'h1) cmp_uw = ((ph + PER - PER / 6) % PER) < PER / 2;
    if (spin == 2'h2) cmp_uw = ((ph + PER / 6) % PER) < PER / 2;
  end
  // lowest inductance on the aligned pair reaches the limit first
  assign current_at_limit = rise >= ((drive == best_pat) ? 3 : 6);
endmodule // motor_model

// ==== tb/tb_top.sv ====
/*
  testbench for the start sequencer: random configurations over still, forward and reverse motors.
  assumes the package, the design and the motor model are compiled before it.
*/
`timescale 1ns/1ns
module tb_top;
  import start_seq_pkg::*;
  localparam int TK = 4;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic wake_restart = 1'b0;
  logic dir_pin = 1'b0;
  seq_cfg_s cfg = '0;
  logic [1:0] spin = 2'h0;
  logic [5:0] best_pat = 6'h00;
  logic cmp_uv;
  logic cmp_uw;
  logic current_at_limit;
  phase_drive_s drive;
  seq_state_e state;
  logic [15:0] drive_rate;
  logic [7:0] drive_angle;
  logic [1:0] current_sel;
  int errors = 0;
  int cmp_count = 0;
  int seed = 2538;
  int visits [16];
  int brake_cyc;
  int align_cyc;
  int gap_lo;
  int bad_drv;
  logic [5:0] pairs [$];
  logic [7:0] accel_angle;
  seq_state_e prev_st;
  logic [5:0] prev_drv;

  always #20 mclk = ~mclk;

  start_sequencer #(.STAT_TICK(TK), .BRAKE_TICK(TK), .ALIGN_TICK(TK), .PROBE_GAP(2)) i_dut (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .wake_restart(wake_restart), .dir_pin(dir_pin),
    .cfg(cfg), .cmp_uv(cmp_uv), .cmp_uw(cmp_uw), .current_at_limit(current_at_limit),
    .drive(drive), .state(state), .drive_rate(drive_rate), .drive_angle(drive_angle),
    .current_sel(current_sel));
  motor_model i_motor (.mclk(mclk), .spin(spin), .best_pat(best_pat), .drive(drive),
    .cmp_uv(cmp_uv), .cmp_uw(cmp_uw), .current_at_limit(current_at_limit));
  ////////////////////////////////////////////////////////////////
  // monitor: state visits, phase patterns, probe pulses
  always @(posedge mclk) begin
    prev_st <= state;
    prev_drv <= drive;
    if (state != prev_st) visits[state] <= visits[state] + 1;
    if (state == ST_ACCEL && prev_st == ST_POS_PROBE) accel_angle <= drive_angle;
    if (state == ST_BRAKE) brake_cyc <= brake_cyc + 1;
    if (state == ST_ALIGN) align_cyc <= align_cyc + 1;
    if (state == ST_POS_PROBE && drive.hi_on != 3'h0 && drive != prev_drv) pairs.push_back(drive);
    if (state == ST_POS_PROBE && drive.hi_on == 3'h0 && drive.lo_on != 3'h0) gap_lo <= gap_lo + 1;
    if ((state == ST_SPEED_PROBE && drive != 6'h00) || (state == ST_BRAKE && prev_st == ST_BRAKE &&
        drive != 6'h07) || (state == ST_ALIGN && prev_st == ST_ALIGN && drive != 6'h14))
      bad_drv <= bad_drv + 1;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [5:0] pair_pat(input int k);
    case (k)
      0: return 6'h14;
      1: return 6'h22;
      2: return 6'h0A;
      3: return 6'h11;
      4: return 6'h21;
      default: return 6'h0C;
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_st(input seq_state_e st, input int lim);
    for (int n = 0; n < lim && state !== st; n++) @(negedge mclk);
  endtask

  task automatic run_seq(input seq_state_e st, input int lim);
    @(negedge mclk);
    visits = '{default: 0};
    brake_cyc = 0;
    align_cyc = 0;
    gap_lo = 0;
    bad_drv = 0;
    pairs.delete();
    @(posedge mclk);
    wake_restart <= 1'b1;
    @(posedge mclk);
    wake_restart <= 1'b0;
    @(negedge mclk);
    chk("wake to power on", ST_POWER_ON, state);
    wait_st(st, lim);
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog: six runs of at most 3000 cycles and one of 500, more than tripled
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    seq_cfg_s c;
    logic [63:0] rnd;
    logic [1:0] sp;
    int bi;
    repeat (15) @(posedge mclk);
    @(negedge mclk);
    chk("state in reset", ST_POWER_ON, state);
    chk("drive in reset", 6'h00, drive);
    @(posedge mclk);
    nrst <= 1'b1;
    for (int t = 0; t < 6; t++) begin
      rnd = {$random(seed), $random(seed)};
      c = rnd[33:0];
      sp = (t == 4) ? 2'h1 : (t == 5) ? 2'h2 : 2'h0;
      bi = ($random(seed) & 32'h7FFF) % 6;
      c.speed_probe_enable = (t >= 3);
      c.brake_duration_sel = (t == 0 || t == 3) ? (c.brake_duration_sel | 3'h1) : 3'h0;
      c.position_probe_current_limit = (t == 1 || t == 2) ? (c.position_probe_current_limit | 4'h1) : 4'h0;
      c.probe_release_mode = (t == 2);
      c.stationary_timeout_sel = 2'h3;
      c.handoff_speed_threshold = c.handoff_speed_threshold & 5'h03;
      c.accel_first_order = 3'h7;
      c.accel_second_order = 3'h7;
      @(posedge mclk);
      cfg <= c;
      spin <= sp;
      best_pat <= pair_pat(bi);
      run_seq(ST_RUN, 3000);
      chk("speed probe entered", c.speed_probe_enable, visits[ST_SPEED_PROBE] != 0);
      chk("phase pattern", 0, bad_drv);
      chk("current select", c.open_loop_current_sel, current_sel);
      if (sp == 2'h0) begin
        chk("reached run", 1, state == ST_RUN);
        chk("still to brake decision", 1, visits[ST_BRAKE_JUDGE] != 0);
        chk("brake entered", c.brake_duration_sel != 3'h0, visits[ST_BRAKE] != 0);
        chk("probe entered", c.position_probe_current_limit != 4'h0, visits[ST_POS_PROBE] != 0);
        chk("align entered", c.position_probe_current_limit == 4'h0, visits[ST_ALIGN] != 0);
        if (c.brake_duration_sel != 3'h0)
          chk_rng("brake length", TK << c.brake_duration_sel, (TK << c.brake_duration_sel) + 2, brake_cyc);
        if (c.position_probe_current_limit == 4'h0)
          chk_rng("align length", TK << c.align_duration_sel, (TK << c.align_duration_sel) + 2, align_cyc);
        else begin
          chk("probe pulse count", 6, pairs.size());
          for (int k = 0; k < 6; k++) chk("probe pair", pair_pat(k), pairs[k]);
          chk("probe angle", 8'((bi * 60 + c.probe_advance_angle * 30) % 256), accel_angle);
          chk("low side held", !c.probe_release_mode, gap_lo != 0);
        end
      end
      if (sp == 2'h1) begin
        chk("forward straight to run", 1, state == ST_RUN && visits[ST_ACCEL] == 0);
        chk("forward skips brake", 0, visits[ST_BRAKE_JUDGE] + visits[ST_REV_JUDGE]);
        chk("resync rate seeded", 1, drive_rate != 16'h0000);
      end
      if (sp == 2'h2) begin
        chk("reverse judged", 1, visits[ST_REV_JUDGE] != 0);
        chk("reverse drive gated", 0, visits[ST_REV_DRIVE] != 0 && !c.reverse_drive_enable);
      end
      $display("test %0d done", t);
    end
    // direction change in mid brake
    c.speed_probe_enable = 1'b0;
    c.brake_duration_sel = 3'h7;
    @(posedge mclk);
    cfg <= c;
    spin <= 2'h0;
    run_seq(ST_BRAKE, 500);
    @(posedge mclk);
    dir_pin <= ~dir_pin;
    @(posedge mclk);
    @(negedge mclk);
    chk("dir change restart", ST_POWER_ON, state);
    chk("dir change drive off", 6'h00, drive);
    $display("test 6 done");
    wrap_up();
  end
endmodule // tb_top
